//--- rtl/fss_pkg.sv
// package for the fault status summary block: command codes, bit positions,
// reset values and the struct that carries the fault detector inputs.
// assumes nothing beyond a SystemVerilog compiler.
package fss_pkg;
    // command codes as seen by the management bus transaction layer
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;

    // reset values
    localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
    localparam logic [5:0] STICKY_RESET = 6'h00;

    // low byte bit positions
    localparam int LOW_BUSY = 7;
    localparam int LOW_OFF = 6;
    localparam int LOW_OV = 5;
    localparam int LOW_OC = 4;
    localparam int LOW_UV = 3;
    localparam int LOW_OT = 2;
    localparam int LOW_CML = 1;
    localparam int LOW_OTHER = 0;

    // high byte bit positions
    localparam int HIGH_VOUT = 7;
    localparam int HIGH_IOUT = 6;
    localparam int HIGH_PGOOD_N = 3;

    // sticky vector slots
    localparam int STK_BUSY = 5;
    localparam int STK_OV = 4;
    localparam int STK_OC = 3;
    localparam int STK_OT = 2;
    localparam int STK_CML = 1;
    localparam int STK_OTHER = 0;
    localparam int STK_WIDTH = 6;

    // raw fault indications from the detectors, asynchronous to mclk
    typedef struct packed {
        logic busyFault;
        logic notSwitching;
        logic absOvpTrip;
        logic normOvpTrip;
        logic ocShutdown;
        logic otShutdown;
        logic commsFault;
        logic logicFault;
        logic otherFault;
        logic [7:0] voutDetail;
        logic [7:0] ioutDetail;
        logic powerGoodOutput;
    } fss_fault_s;
endpackage

//--- rtl/fss_sticky_flags.sv
// vector of sticky flags: set by hardware, cleared by one clear strobe.
// assumes set and clear are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module fss_sticky_flags #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] setIn,
    input wire logic clearAll,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // set wins over clear so a fault still present re-asserts at once
    always_comb begin
        flags_next = (clearAll ? '0 : flags_reg) | setIn;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= RESET_VALUE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule // fss_sticky_flags
`default_nettype wire

//--- rtl/fss_status_regs.sv
// fault status summary: status byte and status word behind command codes.
// assumes the bus transaction layer runs on mclk and the fault detectors do not.
`timescale 1ns/1ps
`default_nettype none
module fss_status_regs (
    input wire logic mclk,
    input wire logic reset_n,
    input wire fss_pkg::fss_fault_s faultIn,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    output logic [15:0] readData,
    output logic readValid,
    output logic [15:0] statusWord
);
    localparam int FW = $bits(fss_pkg::fss_fault_s);
    // power good synchroniser resets to good so the word reads zero
    localparam logic [FW-1:0] SYNC_RESET = FW'(1);

    // synchroniser stages, read answer and status assembly
    fss_pkg::fss_fault_s syncA_reg;
    fss_pkg::fss_fault_s syncB_reg;
    logic [15:0] readData_reg;
    logic [15:0] readData_next;
    logic readValid_reg;
    logic readValid_next;
    logic clearCmd;
    logic readCmd;
    logic [5:0] stickySet;
    logic [5:0] sticky;
    logic [7:0] lowByte;
    logic [7:0] highByte;

    // two-stage synchroniser; only the second stage feeds any logic
    // detail vectors are only summarised bit by bit, so skew between bits
    // delays a summary by a cycle at most; no handshake is needed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_reg <= SYNC_RESET;
            syncB_reg <= SYNC_RESET;
        end else begin
            syncA_reg <= faultIn;
            syncB_reg <= syncA_reg;
        end
    end

    // command decode from the transaction layer
    // write codes other than clear fall through with no effect
    assign clearCmd = cmdValid && cmdWrite && (cmdCode == fss_pkg::CMD_CLEAR_FAULTS);
    assign readCmd = cmdValid && !cmdWrite;

    // latched fault causes
    // a cause lasting one synchronised cycle is enough to latch
    always_comb begin
        stickySet = '0;
        stickySet[fss_pkg::STK_BUSY] = syncB_reg.busyFault;
        stickySet[fss_pkg::STK_OV] = syncB_reg.absOvpTrip | syncB_reg.normOvpTrip;
        stickySet[fss_pkg::STK_OC] = syncB_reg.ocShutdown;
        stickySet[fss_pkg::STK_OT] = syncB_reg.otShutdown;
        stickySet[fss_pkg::STK_CML] = syncB_reg.commsFault | syncB_reg.logicFault;
        stickySet[fss_pkg::STK_OTHER] = syncB_reg.otherFault;
    end

    // one shared clear strobe; set wins inside the flag module
    fss_sticky_flags #(
        .WIDTH(fss_pkg::STK_WIDTH),
        .RESET_VALUE(fss_pkg::STICKY_RESET)
    ) fss_sticky_flags_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .setIn(stickySet),
        .clearAll(clearCmd),
        .flags(sticky)
    );

    // status assembly; summary bits are live since the detail registers latch
    always_comb begin
        lowByte = 8'h00;
        lowByte[fss_pkg::LOW_BUSY] = sticky[fss_pkg::STK_BUSY];
        lowByte[fss_pkg::LOW_OFF] = syncB_reg.notSwitching;
        lowByte[fss_pkg::LOW_OV] = sticky[fss_pkg::STK_OV];
        lowByte[fss_pkg::LOW_OC] = sticky[fss_pkg::STK_OC];
        lowByte[fss_pkg::LOW_UV] = 1'b0;
        lowByte[fss_pkg::LOW_OT] = sticky[fss_pkg::STK_OT];
        lowByte[fss_pkg::LOW_CML] = sticky[fss_pkg::STK_CML];
        lowByte[fss_pkg::LOW_OTHER] = sticky[fss_pkg::STK_OTHER];
        // high byte: live summaries, reserved bits left at zero
        highByte = 8'h00;
        highByte[fss_pkg::HIGH_VOUT] = |syncB_reg.voutDetail;
        highByte[fss_pkg::HIGH_IOUT] = |syncB_reg.ioutDetail;
        highByte[fss_pkg::HIGH_PGOOD_N] = ~syncB_reg.powerGoodOutput;
    end

    assign statusWord = {highByte, lowByte};

    // read answer: data captured in the request cycle, valid one cycle later
    // back-to-back reads are fine; each gets its own answer pulse
    always_comb begin
        readValid_next = readCmd;
        readData_next = readData_reg;
        if (readCmd) begin
            if (cmdCode == fss_pkg::CMD_STATUS_WORD) begin
                readData_next = statusWord;
            end else if (cmdCode == fss_pkg::CMD_STATUS_BYTE) begin
                readData_next = {8'h00, lowByte};
            end else begin
                readData_next = 16'h0000; // other codes belong to other blocks
            end
        end
    end

    // read answer registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            readData_reg <= fss_pkg::STATUS_WORD_RESET;
            readValid_reg <= 1'b0;
        end else begin
            readData_reg <= readData_next;
            readValid_reg <= readValid_next;
        end
    end

    // answer outputs come straight from flops
    assign readData = readData_reg;
    assign readValid = readValid_reg;

    // checks: all on mclk, idle while reset is held
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // sticky causes show one cycle after the synchronised input
    chk_busy_set: assert property (syncB_reg.busyFault |=> statusWord[7])
        else $error("busy fault did not set bit 7");
    chk_ov_set: assert property (
        (syncB_reg.absOvpTrip || syncB_reg.normOvpTrip) |=> statusWord[5])
        else $error("overvoltage did not set bit 5");
    chk_oc_set: assert property (syncB_reg.ocShutdown |=> statusWord[4])
        else $error("overcurrent did not set bit 4");
    chk_ot_set: assert property (syncB_reg.otShutdown |=> statusWord[2])
        else $error("overtemperature did not set bit 2");
    chk_cml_set: assert property (
        (syncB_reg.commsFault || syncB_reg.logicFault) |=> statusWord[1])
        else $error("comms or logic fault did not set bit 1");
    chk_other_set: assert property (syncB_reg.otherFault |=> statusWord[0])
        else $error("other fault did not set bit 0");

    // live bits follow the synchronised inputs in the same cycle; reserved and undervoltage bits stay zero
    chk_off_live: assert property (statusWord[6] == syncB_reg.notSwitching)
        else $error("off bit does not follow switching state");
    chk_vout_sum: assert property (statusWord[15] == (|syncB_reg.voutDetail))
        else $error("voltage summary bit wrong");
    chk_iout_sum: assert property (statusWord[14] == (|syncB_reg.ioutDetail))
        else $error("current summary bit wrong");
    chk_pgood_inv: assert property (statusWord[11] != syncB_reg.powerGoodOutput)
        else $error("power good bit not inverted");
    chk_reserved_zero: assert property (
        statusWord[13:12] == 2'b00 && statusWord[10] == 1'b0 && statusWord[9:8] == 2'b00)
        else $error("reserved high bit set");
    chk_uv_zero: assert property (statusWord[3] == 1'b0 && !(readValid && readData[3]))
        else $error("undervoltage bit set");

    // read port: one answer pulse per read, data held between reads
    chk_word_read: assert property (
        (readCmd && cmdCode == fss_pkg::CMD_STATUS_WORD)
        |=> readValid && readData == $past(statusWord))
        else $error("word read returned wrong data");
    chk_byte_read: assert property (
        (readCmd && cmdCode == fss_pkg::CMD_STATUS_BYTE)
        |=> readValid && readData[15:8] == 8'h00 && readData[7:0] == $past(statusWord[7:0]))
        else $error("byte read differs from word low byte");
    chk_other_code: assert property (
        (readCmd && cmdCode != fss_pkg::CMD_STATUS_WORD && cmdCode != fss_pkg::CMD_STATUS_BYTE)
        |=> readValid && readData == 16'h0000)
        else $error("unknown code did not read zero");
    chk_pulse_only: assert property (!readCmd |=> !readValid)
        else $error("answer pulse without a read");
    chk_data_hold: assert property (!readCmd |=> $stable(readData))
        else $error("read data changed without a read");

    // latched bits drop only through the clear command
    chk_hold_busy: assert property (!clearCmd && statusWord[7] |=> statusWord[7])
        else $error("latched busy dropped without clear");
    chk_flag_hold: assert property (!clearCmd && statusWord[5] |=> statusWord[5])
        else $error("latched overvoltage dropped without clear");
    chk_hold_oc: assert property (!clearCmd && statusWord[4] |=> statusWord[4])
        else $error("latched overcurrent dropped without clear");
    chk_hold_ot: assert property (!clearCmd && statusWord[2] |=> statusWord[2])
        else $error("latched overtemperature dropped without clear");
    chk_hold_cml: assert property (!clearCmd && statusWord[1] |=> statusWord[1])
        else $error("latched comms fault dropped without clear");
    chk_hold_other: assert property (!clearCmd && statusWord[0] |=> statusWord[0])
        else $error("latched other fault dropped without clear");
    chk_clear_all: assert property (
        (clearCmd && stickySet == 6'h00)
        |=> {statusWord[7], statusWord[5:4], statusWord[2:0]} == 6'h00)
        else $error("clear command left a flag set");
    chk_clear_reset: assert property (
        (clearCmd && syncB_reg.ocShutdown) |=> statusWord[4])
        else $error("present fault not re-set after clear");

    // main scenarios
    cov_word_read: cover property (readCmd && cmdCode == fss_pkg::CMD_STATUS_WORD);
    cov_byte_read: cover property (readCmd && cmdCode == fss_pkg::CMD_STATUS_BYTE);
    cov_clear_fault: cover property (statusWord[4] ##1 clearCmd ##1 !statusWord[4]);
    cov_clear_race: cover property (clearCmd && syncB_reg.busyFault);
    cov_pgood_lost: cover property ($rose(statusWord[11]));
endmodule // fss_status_regs
`default_nettype wire

//--- dv/fss_host_model.sv
// host model: issues management bus commands as one-cycle strobes.
// assumes the device answers reads with a registered readValid pulse.
`timescale 1ns/1ps
`default_nettype none
module fss_host_model (
    input wire logic mclk,
    output logic cmdValid,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    input wire logic [15:0] readData,
    input wire logic readValid
);
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
    end
    // one command; released lines get the inverse so stale values never look valid
    task automatic send(input logic wr, input logic [7:0] code,
                        output logic [15:0] data, output bit ok);
        int i;
        @(posedge mclk);
        #1;
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdCode = code;
        @(posedge mclk);
        #1;
        cmdValid = 1'b0;
        cmdWrite = ~wr;
        cmdCode = ~code;
        ok = wr;
        data = 16'h0000;
        // bounded wait for the answer pulse
        for (i = 0; i < 3 && !ok; i++) begin
            if (readValid === 1'b1) begin
                ok = 1'b1;
                data = readData;
            end else begin
                @(posedge mclk);
                #1;
            end
        end
    endtask
endmodule // fss_host_model
`default_nettype wire

//--- dv/fss_status_regs_tb.sv
// testbench for the fault status summary registers.
// assumes the host model drives the command port and faults are driven here.
`timescale 1ns/1ps
`default_nettype none
module fss_status_regs_tb;
    logic mclk;
    logic reset_n;
    fss_pkg::fss_fault_s flt;
    logic cmdValid;
    logic cmdWrite;
    logic [7:0] cmdCode;
    logic [15:0] readData;
    logic readValid;
    logic [15:0] statusWord;
    logic [15:0] rd;
    bit ok;
    int n_fail = 0;
    int cmp_count = 0;
    int src[8] = '{25, 23, 22, 21, 20, 19, 18, 17};
    int pos[8] = '{7, 5, 5, 4, 2, 1, 1, 0};
    fss_status_regs fss_status_regs_inst (.mclk(mclk), .reset_n(reset_n), .faultIn(flt),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .readData(readData), .readValid(readValid), .statusWord(statusWord));
    fss_host_model fss_host_model_inst (.mclk(mclk), .cmdValid(cmdValid),
        .cmdWrite(cmdWrite), .cmdCode(cmdCode), .readData(readData), .readValid(readValid));
    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // read through the host; a missing answer ends the run
    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        fss_host_model_inst.send(1'b0, code, rd, ok);
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: no answer", $time);
            complete_run();
        end else begin
            chk(rd, exp);
        end
    endtask
    task automatic clear_faults();
        fss_host_model_inst.send(1'b1, fss_pkg::CMD_CLEAR_FAULTS, rd, ok);
    endtask
    // covers the two-flop sync plus the sticky stage
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic t_sticky();
        logic [15:0] e;
        for (int k = 0; k < 8; k++) begin
            flt[src[k]] = 1'b1;
            repeat (2) @(posedge mclk);
            #1;
            flt[src[k]] = 1'b0;
            settle();
            e = 16'h0001 << pos[k];
            chk(statusWord, e);
            rd_chk(fss_pkg::CMD_STATUS_BYTE, e);
            clear_faults();
            settle();
            rd_chk(fss_pkg::CMD_STATUS_WORD, 16'h0000);
        end
        $display("sticky test done");
    endtask
    task automatic t_live();
        flt.notSwitching = 1'b1;
        settle();
        chk(statusWord, 16'h0001 << fss_pkg::LOW_OFF);
        flt.notSwitching = 1'b0;
        flt.voutDetail = 8'h80;
        settle();
        chk(statusWord, 16'h0100 << fss_pkg::HIGH_VOUT);
        flt.voutDetail = 8'h00;
        flt.ioutDetail = 8'h01;
        settle();
        chk(statusWord, 16'h0100 << fss_pkg::HIGH_IOUT);
        flt.ioutDetail = 8'h00;
        flt.powerGoodOutput = 1'b0;
        settle();
        rd_chk(fss_pkg::CMD_STATUS_WORD, 16'h0100 << fss_pkg::HIGH_PGOOD_N);
        flt.powerGoodOutput = 1'b1;
        settle();
        chk(statusWord, 16'h0000);
        $display("live test done");
    endtask
    task automatic t_all();
        flt = '1;
        flt.powerGoodOutput = 1'b0;
        settle();
        rd_chk(fss_pkg::CMD_STATUS_WORD, 16'hc8f7);
        rd_chk(fss_pkg::CMD_STATUS_BYTE, 16'h00f7);
        clear_faults();
        rd_chk(fss_pkg::CMD_STATUS_WORD, 16'hc8f7);
        flt = '0;
        flt.powerGoodOutput = 1'b1;
        settle();
        rd_chk(fss_pkg::CMD_STATUS_WORD, 16'h00b7);
        fss_host_model_inst.send(1'b1, fss_pkg::CMD_STATUS_BYTE, rd, ok);
        rd_chk(8'h20, 16'h0000);
        chk(statusWord, 16'h00b7);
        reset_n = 1'b0;
        #1;
        chk(statusWord, fss_pkg::STATUS_WORD_RESET);
        @(posedge mclk);
        #1;
        reset_n = 1'b1;
        settle();
        rd_chk(fss_pkg::CMD_STATUS_WORD, 16'h0000);
        $display("all-faults test done");
    endtask
    initial begin
        flt = '0;
        flt.powerGoodOutput = 1'b1;
        reset_n = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        settle();
        rd_chk(fss_pkg::CMD_STATUS_WORD, fss_pkg::STATUS_WORD_RESET);
        t_sticky();
        t_live();
        t_all();
        complete_run();
    end
endmodule // fss_status_regs_tb
`default_nettype wire
